// >>> verilog/ddsprb_bank.sv
// profile register bank: byte-parallel register port, profile words, control function register
module ddsprb_bank (
  input  wire logic                               ref_clk_in,
  input  wire logic                               nrst_in,
  input  wire ddsprb_pkg::ddsprb_pins_s           pins_in,
  input  wire ddsprb_pkg::ddsprb_pump_e           pump_mode_in,
  output logic [ddsprb_pkg::DATA_W-1:0]           rd_data_out,
  output logic [ddsprb_pkg::FTW_W-1:0]            control_function_out,
  output logic [ddsprb_pkg::FTW_W-1:0]            active_ftw_out,
  output logic [ddsprb_pkg::POW_W-1:0]            active_pow_out,
  output logic [5:0]                              fd_pump_mult_out
);
  import ddsprb_pkg::*;

  ddsprb_state_s st_r;
  ddsprb_state_s st_nxt;
  logic          wr_evt;
  logic          upd_evt;

  // edges are taken from the second sync stage only
  assign wr_evt  = st_r.s2.wr & ~st_r.wr_prev;
  assign upd_evt = st_r.s2.update & ~st_r.upd_prev;

  always_comb begin
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] rd;
    base   = '0;
    a      = st_r.s2.addr;
    d      = st_r.s2.data;
    rd     = '0;
    st_nxt = st_r;
    st_nxt.s1       = pins_in;
    st_nxt.s2       = st_r.s1;
    st_nxt.wr_prev  = st_r.s2.wr;
    st_nxt.upd_prev = st_r.s2.update;

    // control function bytes, byte n holds bits 8n+7:8n
    if (a <= PAR_CFR_LAST) begin
      rd = st_r.control_function[a[1:0]*8 +: 8];
      if (wr_evt) begin
        st_nxt.control_function[a[1:0]*8 +: 8] = d;
      end
    end

    // profiles one to three share one layout, stride of six bytes
    for (int p = 0; p < NPROF; p++) begin
      base = PAR_PROF1_FTW + ADDR_W'(p) * PAR_PROF_STRIDE;
      if (a >= base && a < base + PAR_POW_OFFSET) begin
        rd = st_r.ftw[p][(a - base)*8 +: 8];
        if (wr_evt) begin
          st_nxt.ftw[p][(a - base)*8 +: 8] = d;
        end
      end
      if (a == base + PAR_POW_OFFSET) begin
        rd = st_r.pow[p][7:0];
        if (wr_evt) begin
          st_nxt.pow[p][7:0] = d;
        end
      end
      if (a == base + PAR_POW_OFFSET + 6'h01) begin
        rd = {2'h0, st_r.pow[p][13:8]};
        if (wr_evt) begin
          st_nxt.pow[p][13:8] = d[5:0];
        end
      end
    end

    // reserved pair is read only; a write there is dropped so the contents survive
    if (a == PAR_RSVD_LO) begin
      rd = RSVD_LO_VALUE;
    end
    if (a == PAR_RSVD_HI) begin
      rd = RSVD_HI_VALUE;
    end

    if (st_r.s2.rd) begin
      st_nxt.rd_data = rd;
    end

    // staged words reach the datapath only on update; profile 0 lives elsewhere
    if (upd_evt && st_r.s2.profile != 2'h0) begin
      st_nxt.act_ftw = st_r.ftw[st_r.s2.profile - 2'h1];
      st_nxt.act_pow = st_r.pow[st_r.s2.profile - 2'h1];
    end

    // other pump modes read their own fields downstream
    if (pump_mode_in == PUMP_FREQ_DETECT) begin
      case (st_r.control_function[FD_FIELD_HI:FD_FIELD_LO])
        2'h0:    st_nxt.fd_mult = FD_MULT_0;
        2'h1:    st_nxt.fd_mult = FD_MULT_20;
        2'h2:    st_nxt.fd_mult = FD_MULT_40;
        2'h3:    st_nxt.fd_mult = FD_MULT_60;
        default: st_nxt.fd_mult = FD_MULT_0;
      endcase
    end else begin
      st_nxt.fd_mult = FD_MULT_0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r     <= '0;
      st_r.control_function <= CFR_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data_out          = st_r.rd_data;
  assign control_function_out = st_r.control_function;
  assign active_ftw_out       = st_r.act_ftw;
  assign active_pow_out       = st_r.act_pow;
  assign fd_pump_mult_out     = st_r.fd_mult;

  // checks
  sequence s_wr(logic [ADDR_W-1:0] ad);
    wr_evt && st_r.s2.addr == ad;
  endsequence

  sequence s_rd(logic [ADDR_W-1:0] ad);
    st_r.s2.rd && st_r.s2.addr == ad;
  endsequence

  sequence s_upd(logic [1:0] pr);
    upd_evt && st_r.s2.profile == pr;
  endsequence

  a_profile1_phase_offset_high_byte: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    s_wr(6'h15) |=> st_r.pow[0][13:8] == $past(st_r.s2.data[5:0]))
    else $error("profile one phase high bits not stored");

  a_profile3_frequency_tuning_top_byte: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    s_wr(6'h1f) |=> st_r.ftw[2][31:24] == $past(st_r.s2.data))
    else $error("profile three tuning top byte wrong");

  a_profile2_phase_offset_unused_bits: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    s_rd(6'h1b) |=> rd_data_out[7:6] == 2'h0 && rd_data_out[5:0] == $past(st_r.pow[1][13:8]))
    else $error("profile two phase high byte readback wrong");

  a_profile3_phase_offset_low_byte: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    s_wr(6'h20) |=> st_r.pow[2][7:0] == $past(st_r.s2.data))
    else $error("profile three phase low byte not stored");

  // the reserved pair reads its fixed contents whatever the host has done
  a_rsvd_pair_kept: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    s_rd(6'h22) |=> rd_data_out == 8'hfe)
    else $error("reserved low byte contents changed");

  a_rsvd_hi_read: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    s_rd(6'h23) |=> rd_data_out == 8'hff)
    else $error("reserved high byte contents changed");

  a_cfr_msb_byte: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    s_wr(6'h03) |=> control_function_out[31:24] == $past(st_r.s2.data))
    else $error("control function top byte wrong");

  a_fd_scale_value: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    pump_mode_in == PUMP_FREQ_DETECT && st_r.control_function[31:30] == 2'h3 |=> fd_pump_mult_out == 6'h3c)
    else $error("frequency detect scale wrong");

  a_fd_scale_gate: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    pump_mode_in != PUMP_FREQ_DETECT |=> fd_pump_mult_out == 6'h00)
    else $error("scale applied outside frequency detect");

  a_update_loads: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    upd_evt && st_r.s2.profile == 2'h2 |=> active_ftw_out == $past(st_r.ftw[1]))
    else $error("update did not load selected profile");

  a_no_update_hold: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    !upd_evt |=> $stable(active_ftw_out) && $stable(active_pow_out))
    else $error("datapath words changed without update");

  a_profile1_frequency_tuning_low_byte: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    s_wr(6'h10) |=> st_r.ftw[0][7:0] == $past(st_r.s2.data))
    else $error("profile one tuning low byte wrong");

  a_profile1_phase_offset_low_byte: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    s_wr(6'h14) |=> st_r.pow[0][7:0] == $past(st_r.s2.data))
    else $error("profile one phase low byte not stored");

  a_profile2_phase_offset_low_byte: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    s_wr(6'h1a) |=> st_r.pow[1][7:0] == $past(st_r.s2.data))
    else $error("profile two phase low byte not stored");

  a_profile3_phase_offset_high_byte: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    s_wr(6'h21) |=> st_r.pow[2][13:8] == $past(st_r.s2.data[5:0]))
    else $error("profile three phase high bits not stored");

  a_cfr_low_byte: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    s_wr(6'h00) |=> control_function_out[7:0] == $past(st_r.s2.data))
    else $error("control function low byte wrong");

  a_profile2_frequency_tuning_low_byte: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    s_wr(6'h16) |=> st_r.ftw[1][7:0] == $past(st_r.s2.data))
    else $error("profile two tuning low byte wrong");

  // the scale follows the field one cycle late, and only in frequency detect mode
  a_fd_scale_twenty: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    pump_mode_in == PUMP_FREQ_DETECT && st_r.control_function[31:30] == 2'h1 |=> fd_pump_mult_out == 6'h14)
    else $error("frequency detect scale of twenty wrong");

  a_fd_scale_forty: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    pump_mode_in == PUMP_FREQ_DETECT && st_r.control_function[31:30] == 2'h2 |=> fd_pump_mult_out == 6'h28)
    else $error("frequency detect scale of forty wrong");

  a_update_ignored: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    s_upd(2'h0) |=> $stable(active_ftw_out) && $stable(active_pow_out))
    else $error("update of profile zero changed datapath words");

endmodule

// >>> verilog/ddsprb_pkg.sv
// package for the profile register bank: address map, field layout, reset values and types
package ddsprb_pkg;

  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FTW_W  = 32;
  localparam int unsigned POW_W  = 14;
  localparam int unsigned NPROF  = 3;

  // serial register indices
  localparam logic [4:0] SER_CONTROL_FUNCTION = 5'h00;
  localparam logic [4:0] SER_PROFILE1_FTW     = 5'h05;
  localparam logic [4:0] SER_PROFILE1_POW     = 5'h06;
  localparam logic [4:0] SER_PROFILE2_FTW     = 5'h07;
  localparam logic [4:0] SER_PROFILE2_POW     = 5'h08;
  localparam logic [4:0] SER_PROFILE3_FTW     = 5'h09;
  localparam logic [4:0] SER_PROFILE3_POW     = 5'h0a;
  localparam logic [4:0] SER_RESERVED_PAIR    = 5'h0b;

  // parallel byte addresses
  localparam logic [ADDR_W-1:0] PAR_CFR_BASE    = 6'h00;
  localparam logic [ADDR_W-1:0] PAR_CFR_LAST    = 6'h03;
  localparam logic [ADDR_W-1:0] PAR_PROF1_FTW   = 6'h10;
  localparam logic [ADDR_W-1:0] PAR_PROF_STRIDE = 6'h06;
  localparam logic [ADDR_W-1:0] PAR_POW_OFFSET  = 6'h04;
  localparam logic [ADDR_W-1:0] PAR_RSVD_LO     = 6'h22;
  localparam logic [ADDR_W-1:0] PAR_RSVD_HI     = 6'h23;

  localparam logic [DATA_W-1:0] RSVD_LO_VALUE = 8'hfe;
  localparam logic [DATA_W-1:0] RSVD_HI_VALUE = 8'hff;
  localparam logic [FTW_W-1:0]  CFR_RESET     = 32'h0000_0018;

  // frequency detect pump current field and its multiples of the baseline current
  localparam int unsigned     FD_FIELD_HI = 31;
  localparam int unsigned     FD_FIELD_LO = 30;
  localparam logic [5:0]      FD_MULT_0   = 6'h00;
  localparam logic [5:0]      FD_MULT_20  = 6'h14;
  localparam logic [5:0]      FD_MULT_40  = 6'h28;
  localparam logic [5:0]      FD_MULT_60  = 6'h3c;

  typedef enum logic [1:0] {
    PUMP_IDLE         = 2'h0,
    PUMP_FREQ_DETECT  = 2'h1,
    PUMP_FINAL_CLOSED = 2'h2,
    PUMP_WIDE_CLOSED  = 2'h3
  } ddsprb_pump_e;

  // byte-parallel port pins plus update and profile select pins
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              wr;
    logic              rd;
    logic              update;
    logic [1:0]        profile;
  } ddsprb_pins_s;

  typedef struct packed {
    ddsprb_pins_s                 s1;
    ddsprb_pins_s                 s2;
    logic                         wr_prev;
    logic                         upd_prev;
    logic [NPROF-1:0][FTW_W-1:0]  ftw;
    logic [NPROF-1:0][POW_W-1:0]  pow;
    logic [FTW_W-1:0]             control_function;
    logic [FTW_W-1:0]             act_ftw;
    logic [POW_W-1:0]             act_pow;
    logic [DATA_W-1:0]            rd_data;
    logic [5:0]                   fd_mult;
  } ddsprb_state_s;

endpackage

// >>> dv/ddsprb_host.sv
// host controller model driving the byte-parallel register port
module ddsprb_host import ddsprb_pkg::*; (
  input  wire logic                clk_in,
  input  wire logic [7:0]          rd_data_in,
  output ddsprb_pkg::ddsprb_pins_s pins_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    pins_out = '0;
    pins_out.data = 8'h5a;
  end
  // released address and data lines flip so stale values are never mistaken for held ones
  task automatic wr_byte(input logic [5:0] a, input logic [7:0] d);
    if (a == PAR_RSVD_LO || a == PAR_RSVD_HI) return;
    @(negedge clk_in);
    pins_out.addr = a;
    pins_out.data = d;
    repeat (3) @(negedge clk_in);
    pins_out.wr = 1'b1;
    repeat (3) @(negedge clk_in);
    pins_out.wr = 1'b0;
    pins_out.addr = ~a;
    pins_out.data = ~d;
    repeat (2) @(negedge clk_in);
  endtask
  task automatic rd_byte(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk_in);
    pins_out.addr = a;
    pins_out.rd = 1'b1;
    repeat (4) @(negedge clk_in);
    d = rd_data_in;
    pins_out.rd = 1'b0;
    pins_out.addr = ~a;
  endtask
  task automatic update(input logic [1:0] p);
    @(negedge clk_in);
    pins_out.profile = p;
    pins_out.update = 1'b1;
    repeat (3) @(negedge clk_in);
    pins_out.update = 1'b0;
    repeat (2) @(negedge clk_in);
  endtask
endmodule

// >>> dv/ddsprb_bank_tb.sv
// self-checking bench for the profile register bank
module ddsprb_bank_tb import ddsprb_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic         ref_clk   = 1'b0;
  logic         nrst      = 1'b0;
  ddsprb_pump_e pump_mode = PUMP_IDLE;
  ddsprb_pins_s pins;
  logic [7:0]   rd_data;
  logic [31:0]  control_function;
  logic [31:0]  aftw;
  logic [13:0]  apow;
  logic [5:0]   fdm;
  logic [7:0]   got;
  int           miscompares = 0;
  int           num_checks  = 0;
  int           cycles      = 0;
  // rows: address, written byte, byte read back
  localparam logic [23:0] ROWS [27] = '{24'h00a1a1, 24'h01b2b2, 24'h02c3c3, 24'h038080,
    24'h101111, 24'h112222, 24'h123333, 24'h134444, 24'h145555, 24'h15ff3f,
    24'h166666, 24'h177777, 24'h188888, 24'h199999, 24'h1aaaaa, 24'h1bee2e,
    24'h1cabab, 24'h1dcdcd, 24'h1eefef, 24'h1f0101, 24'h202323, 24'h21c505,
    24'h085a00, 24'h245a00, 24'h3f5a00, 24'h2200fe, 24'h2300ff};
  localparam logic [31:0] EFTW [4] = '{32'h0, 32'h44332211, 32'h99887766, 32'h01efcdab};
  localparam logic [13:0] EPOW [4] = '{14'h0, 14'h3f55, 14'h2eaa, 14'h0523};
  localparam logic [5:0]  MULT [4] = '{FD_MULT_0, FD_MULT_20, FD_MULT_40, FD_MULT_60};

  always #2 ref_clk = ~ref_clk;

  ddsprb_host host (.clk_in(ref_clk), .rd_data_in(rd_data), .pins_out(pins));
  ddsprb_bank DUT (.ref_clk_in(ref_clk), .nrst_in(nrst), .pins_in(pins), .pump_mode_in(pump_mode),
    .rd_data_out(rd_data), .control_function_out(control_function), .active_ftw_out(aftw),
    .active_pow_out(apow), .fd_pump_mult_out(fdm));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // a whole run needs well under two thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      stop_test();
    end
  end

  initial begin
    repeat (10) @(negedge ref_clk);
    nrst = 1'b1;
    @(negedge ref_clk);
    check(control_function, CFR_RESET);
    check(aftw, 32'h0);
    check(fdm, 6'h00);
    check(apow, 14'h0000);
    // written top down, read bottom up: byte order must not matter
    for (int i = 26; i >= 0; i--) host.wr_byte(ROWS[i][21:16], ROWS[i][15:8]);
    for (int i = 0; i < 27; i++) begin
      host.rd_byte(ROWS[i][21:16], got);
      check(got, ROWS[i][7:0]);
    end
    check(control_function, 32'h80c3b2a1);
    for (int p = 1; p < 4; p++) begin
      host.update(p[1:0]);
      check(aftw, EFTW[p]);
      check(apow, EPOW[p]);
    end
    host.update(2'h0);
    check(aftw, EFTW[3]);
    check(apow, EPOW[3]);
    host.wr_byte(6'h1c, 8'h12);
    check(aftw, EFTW[3]);
    host.update(2'h3);
    check(aftw, 32'h01efcd12);
    for (int c = 0; c < 4; c++) begin
      host.wr_byte(6'h03, {c[1:0], 6'h00});
      check(control_function[31:30], c[1:0]);
      for (int m = 0; m < 4; m++) begin
        @(negedge ref_clk);
        pump_mode = ddsprb_pump_e'(m[1:0]);
        repeat (2) @(negedge ref_clk);
        check(fdm, (m == 1) ? MULT[c] : 6'h00);
      end
    end
    @(negedge ref_clk);
    nrst = 1'b0;
    #1;
    check(control_function, CFR_RESET);
    check(aftw, 32'h0);
    check(apow, 14'h0000);
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    host.rd_byte(6'h1c, got);
    check(got, 8'h00);
    stop_test();
  end
endmodule
